// file: hw/pio_pkg.sv
// Package for the seven-port parallel I/O block.
// Assumes an 8-bit register port with page-zero and high-page windows.
package pio_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    // Port index: A..G
    localparam int PORT_G = 6;
    localparam int OSCILLATOR_OUTPUT_OUT_BIT = 5;
    localparam int OSCILLATOR_OUTPUT_IN_BIT = 6;
    // ==========================================================
    // Register map: page zero holds data and direction,
    // high page holds pullup, slew and drive.
    localparam logic [15:0] PAGE0_BASE = 16'h0000;
    localparam logic [15:0] HIGH_BASE = 16'h1840;
    localparam logic [15:0] PORT_STRIDE = 16'h0002;
    localparam logic [15:0] HIGH_STRIDE = 16'h0004;
    localparam logic [1:0] OFS_DATA = 2'h0;
    localparam logic [1:0] OFS_DIR = 2'h1;
    localparam logic [1:0] OFS_PULL = 2'h0;
    localparam logic [1:0] OFS_SLEW = 2'h1;
    localparam logic [1:0] OFS_DRIVE = 2'h2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] SLEW_RST = 8'hFF;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    // Implemented pins per port, A..G
    localparam logic [7:0] IMPL_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h7F};

    // Per-port software state
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] slew;
        logic [7:0] drive;
    } port_regs_type;

    // Peripheral override for one port
    typedef struct packed {
        logic [7:0] dig_en;
        logic [7:0] dig_oe;
        logic [7:0] dig_out;
        logic [7:0] ana_en;
        logic [7:0] kbd_en;
    } periph_type;
endpackage

// file: hw/pio_port.sv
// Parallel I/O ports with pin sharing, registers and pin muxing.
// Assumes pins arrive asynchronously and peripheral controls are on CLK.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

module pio_port #(
    parameter int NUM_PORTS = pio_pkg::NUM_PORTS
) (
    input wire logic CLK, // 50 MHz clock
    input wire logic SYS_RST, // Synchronous reset, high
    input wire logic [15:0] ADDR, // Register address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after RD
    input wire logic [NUM_PORTS*8-1:0] PIN_IN, // Pin levels, async
    output logic [NUM_PORTS*8-1:0] PIN_OUT, // Pin drive value
    output logic [NUM_PORTS*8-1:0] PIN_OE_N, // Pin enable, low drives
    output logic [NUM_PORTS*8-1:0] PULL_EN, // Effective pullup
    output logic [NUM_PORTS*8-1:0] SLEW_EN, // Slew control
    output logic [NUM_PORTS*8-1:0] DRIVE_HI, // High drive
    input wire pio_pkg::periph_type [NUM_PORTS-1:0] PERIPH, // Peripheral overrides
    input wire logic OSC_EN, // External oscillator on
    output logic [NUM_PORTS*8-1:0] PERIPH_IN // Pin levels to peripherals
);
    // ==========================================================
    // Address decode
    // True when address a selects register ofs of port p in the window at base
    function automatic logic hit(
        input logic [15:0] a,
        input logic [15:0] base,
        input logic [15:0] stride,
        input int p,
        input logic [1:0] ofs
    );
        logic [15:0] t;
        t = 16'(base + 16'(p) * stride + 16'(ofs));
        return a == t;
    endfunction

    pio_pkg::port_regs_type [NUM_PORTS-1:0] regs_r, regs_nxt;
    logic [NUM_PORTS*8-1:0] sync1_r, sync2_r;
    logic [NUM_PORTS*8-1:0] out_r, out_nxt, oe_n_r, oe_n_nxt;
    logic [NUM_PORTS*8-1:0] pull_r, pull_nxt, slew_r, slew_nxt, drv_r, drv_nxt;
    logic [NUM_PORTS*8-1:0] pin_lvl;
    logic [7:0] rdata_r, rdata_nxt;

    assign pin_lvl = sync2_r;

    // ==========================================================
    // Address decode per port
    // One select per register kind, shared by write and read paths
    // At most one bit of all selects is set for any address
    logic [NUM_PORTS-1:0] sel_data, sel_dir, sel_pull, sel_slew, sel_drive;

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            sel_data[p] = hit(ADDR, pio_pkg::PAGE0_BASE, pio_pkg::PORT_STRIDE, p, pio_pkg::OFS_DATA);
            sel_dir[p] = hit(ADDR, pio_pkg::PAGE0_BASE, pio_pkg::PORT_STRIDE, p, pio_pkg::OFS_DIR);
            sel_pull[p] = hit(ADDR, pio_pkg::HIGH_BASE, pio_pkg::HIGH_STRIDE, p, pio_pkg::OFS_PULL);
            sel_slew[p] = hit(ADDR, pio_pkg::HIGH_BASE, pio_pkg::HIGH_STRIDE, p, pio_pkg::OFS_SLEW);
            sel_drive[p] = hit(ADDR, pio_pkg::HIGH_BASE, pio_pkg::HIGH_STRIDE, p, pio_pkg::OFS_DRIVE);
        end
    end

    // ==========================================================
    // Register writes
    // Unmapped addresses leave every register as it is
    always_comb begin
        regs_nxt = regs_r;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (WR) begin
                if (sel_data[p]) begin
                    regs_nxt[p].data = WDATA;
                end
                if (sel_dir[p]) begin
                    regs_nxt[p].dir = WDATA;
                end
                if (sel_pull[p]) begin
                    regs_nxt[p].pull = WDATA;
                end
                if (sel_slew[p]) begin
                    regs_nxt[p].slew = WDATA;
                end
                if (sel_drive[p]) begin
                    regs_nxt[p].drive = WDATA;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                regs_r[p].data <= pio_pkg::DATA_RST;
                regs_r[p].dir <= pio_pkg::DIR_RST;
                regs_r[p].pull <= pio_pkg::PULL_RST;
                regs_r[p].slew <= pio_pkg::SLEW_RST;
                regs_r[p].drive <= pio_pkg::DRIVE_RST;
            end
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // ==========================================================
    // Pin synchroniser
    // Two stages against metastability; only the second is read
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= PIN_IN;
            sync2_r <= sync1_r;
        end
    end

    // ==========================================================
    // Pin ownership and drive
    // Priority: missing or crystal pin, analog, keyboard,
    // digital peripheral, then the port's own registers
    always_comb begin
        out_nxt = '0;
        oe_n_nxt = '1;
        pull_nxt = '0;
        slew_nxt = '0;
        drv_nxt = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                automatic int i = p * 8 + b;
                automatic logic impl = pio_pkg::IMPL_MASK[p][b];
                automatic logic osc = OSC_EN && (p == pio_pkg::PORT_G) &&
                    (b == pio_pkg::OSCILLATOR_OUTPUT_OUT_BIT || b == pio_pkg::OSCILLATOR_OUTPUT_IN_BIT);
                automatic logic ana = PERIPH[p].ana_en[b];
                automatic logic kbd = (p == pio_pkg::PORT_G) && PERIPH[p].kbd_en[b];
                automatic logic drive_on = 1'b0;
                automatic logic val = 1'b0;
                if (!impl || osc) begin
                    drive_on = 1'b0;
                end else if (ana) begin
                    drive_on = 1'b0;
                end else if (kbd) begin
                    drive_on = 1'b0;
                end else if (PERIPH[p].dig_en[b]) begin
                    drive_on = PERIPH[p].dig_oe[b];
                    val = PERIPH[p].dig_out[b];
                end else begin
                    drive_on = regs_r[p].dir[b];
                    val = regs_r[p].data[b];
                end
                out_nxt[i] = val;
                oe_n_nxt[i] = !drive_on;
                if (impl && !osc && !ana) begin
                    pull_nxt[i] = regs_r[p].pull[b] && !drive_on;
                    slew_nxt[i] = regs_r[p].slew[b];
                    drv_nxt[i] = regs_r[p].drive[b];
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            out_r <= '0;
            oe_n_r <= '1;
            pull_r <= '0;
            slew_r <= '0;
            drv_r <= '0;
        end else begin
            out_r <= out_nxt;
            oe_n_r <= oe_n_nxt;
            pull_r <= pull_nxt;
            slew_r <= slew_nxt;
            drv_r <= drv_nxt;
        end
    end

    // ==========================================================
    // Data register view per port
    // Pin side comes from the second synchroniser stage only
    // Crystal-owned pins are not forced; they follow direction
    logic [7:0] data_view [NUM_PORTS];

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                data_view[p][b] = regs_r[p].dir[b] ? regs_r[p].data[b] : pin_lvl[p*8+b];
                if (PERIPH[p].ana_en[b]) begin
                    data_view[p][b] = 1'b0;
                end
            end
            data_view[p] = data_view[p] & pio_pkg::IMPL_MASK[p];
        end
    end

    // ==========================================================
    // Read path
    // Idle and unmapped reads return zero in the following cycle
    always_comb begin
        rdata_nxt = 8'h00;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (RD) begin
                if (sel_data[p]) begin
                    rdata_nxt = data_view[p];
                end
                if (sel_dir[p]) begin
                    rdata_nxt = regs_r[p].dir;
                end
                if (sel_pull[p]) begin
                    rdata_nxt = regs_r[p].pull;
                end
                if (sel_slew[p]) begin
                    rdata_nxt = regs_r[p].slew;
                end
                if (sel_drive[p]) begin
                    rdata_nxt = regs_r[p].drive;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Outputs, each straight from its register
    assign RDATA = rdata_r;
    assign PIN_OUT = out_r;
    assign PIN_OE_N = oe_n_r;
    assign PULL_EN = pull_r;
    assign SLEW_EN = slew_r;
    assign DRIVE_HI = drv_r;
    assign PERIPH_IN = sync2_r;
endmodule // pio_port

// file: verif/pio_pins_model.sv
// Board side of the pins: external levels, open pins and pullups.
// Assumes the block's pin drive, enable and pullup outputs.
`timescale 1ns/1ns
module pio_pins_model (
    input wire logic clk, // Bus clock
    input wire logic [55:0] pin_out, // Drive value
    input wire logic [55:0] pin_oe_n, // Low drives
    input wire logic [55:0] pull_en, // Pullup on
    input wire logic [55:0] ext, // Board level
    input wire logic [55:0] flt, // Pin left open
    output logic [55:0] lvl // Wire level
);
    logic tog = 1'b0;
    always @(posedge clk) tog <= ~tog;
    // =====================================
    // Wire level
    // pullup on open inputs only
    always_comb
        for (int i = 0; i < 56; i++)
            lvl[i] = !pin_oe_n[i] ? pin_out[i] : !flt[i] ? ext[i] : pull_en[i] ? 1'b1 : tog;
endmodule // pio_pins_model

// file: verif/pio_port_assertions.sv
// Checker on the parallel I/O block's ports.
// Assumes the port list of pio_port; bound below.
`timescale 1ns/1ns
module pio_port_assertions #(
    parameter int NUM_PORTS = pio_pkg::NUM_PORTS
) (
    input wire logic CLK, // Clock
    input wire logic SYS_RST, // Reset
    input wire logic [15:0] ADDR, // Address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic [7:0] RDATA, // Read data
    input wire logic [NUM_PORTS*8-1:0] PIN_IN, // Pin levels
    input wire logic [NUM_PORTS*8-1:0] PIN_OUT, // Drive value
    input wire logic [NUM_PORTS*8-1:0] PIN_OE_N, // Low drives
    input wire logic [NUM_PORTS*8-1:0] PULL_EN, // Pullup
    input wire logic [NUM_PORTS*8-1:0] SLEW_EN, // Slew
    input wire logic [NUM_PORTS*8-1:0] DRIVE_HI, // Drive
    input wire pio_pkg::periph_type [NUM_PORTS-1:0] PERIPH, // Overrides
    input wire logic OSC_EN, // Oscillator on
    input wire logic [NUM_PORTS*8-1:0] PERIPH_IN // To peripherals
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence held2(s);
        s ##1 s;
    endsequence
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00) else $error("read data not idle");
    a_unmapped_read: assert property (RD && ADDR == 16'h0100 |=> RDATA == 8'h00) else $error("unmapped read");
    a_reset_idle: assert property ($past(SYS_RST) |-> &PIN_OE_N && PULL_EN == '0) else $error("reset state");
    a_pull_gate: assert property ((PULL_EN & ~PIN_OE_N) == '0) else $error("pullup on output");
    a_unimpl_quiet: assert property (PIN_OE_N[23] && PIN_OE_N[55] && !SLEW_EN[55]) else $error("unimpl pin");
    a_analog_owns: assert property (held2(PERIPH[3].ana_en[7]) |-> PIN_OE_N[31] && !PULL_EN[31])
        else $error("analog pin driven");
    a_dig_drive: assert property (held2(PERIPH[4].dig_en[0] && PERIPH[4].dig_oe[0] && !PERIPH[4].ana_en[0])
        |-> !PIN_OE_N[32] && PIN_OUT[32] == $past(PERIPH[4].dig_out[0])) else $error("periph drive");
    a_kbd_input: assert property (held2(PERIPH[6].kbd_en[0] && !PERIPH[6].ana_en[0]) |-> PIN_OE_N[48])
        else $error("keyboard pin driven");
    a_osc_pins: assert property (held2(OSC_EN) |-> PIN_OE_N[54:53] == 2'h3 && SLEW_EN[54:53] == 2'h0)
        else $error("crystal pins used");
endmodule // pio_port_assertions
bind pio_port pio_port_assertions #(.NUM_PORTS(NUM_PORTS)) chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
    .PULL_EN(PULL_EN), .SLEW_EN(SLEW_EN), .DRIVE_HI(DRIVE_HI), .PERIPH(PERIPH), .OSC_EN(OSC_EN),
    .PERIPH_IN(PERIPH_IN));

// file: verif/tb_top.sv
// Self-checking bench for the parallel I/O block.
// Assumes pio_port, the pin model and the bound checker.
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_type;
    localparam row_type ROWS [13] = '{'{1'b0, 16'h0001, 8'h00, 8'h00}, '{1'b0, 16'h1840, 8'h00, 8'h00},
        '{1'b0, 16'h1841, 8'h00, 8'hFF}, '{1'b0, 16'h1842, 8'h00, 8'h00}, '{1'b1, 16'h0001, 8'hA5, 8'hA5},
        '{1'b1, 16'h1840, 8'h3C, 8'h3C}, '{1'b1, 16'h1841, 8'h0F, 8'h0F}, '{1'b1, 16'h1842, 8'h81, 8'h81},
        '{1'b0, 16'h0001, 8'h00, 8'hA5}, '{1'b1, 16'h0100, 8'h55, 8'h00}, '{1'b1, 16'h000D, 8'hFF, 8'hFF},
        '{1'b1, 16'h1854, 8'hFF, 8'hFF}, '{1'b1, 16'h0003, 8'hFF, 8'hFF}};
    logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, osc_en = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic [55:0] pin_in, pin_out, pin_oe_n, pull_en, slew_en, drive_hi, periph_in;
    logic [55:0] ext = 56'h000000300000C3, flt = 56'h00FF0000000000;
    pio_pkg::periph_type [6:0] periph = '0;
    int failures = 0, compares = 0;
    pio_port dut_u (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PULL_EN(pull_en), .SLEW_EN(slew_en),
        .DRIVE_HI(drive_hi), .PERIPH(periph), .OSC_EN(osc_en), .PERIPH_IN(periph_in));
    pio_pins_model pins_u (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en), .ext(ext),
        .flt(flt), .lvl(pin_in));
    initial forever #10 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask
    task automatic report_and_stop();
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].w) wr_reg(ROWS[i].a, ROWS[i].d);
            rd_reg(ROWS[i].a, d);
            chk("reg row", d, ROWS[i].e);
        end
        wr_reg(16'h0000, 8'h3C);
        settle();
        rd_reg(16'h0000, d);
        chk("data A", d, 8'h66);
        chk("oe A", pin_oe_n[7:0], 8'h5A);
        chk("pull A", pull_en[7:0], 8'h18);
        chk("drive A", drive_hi[7:0], 8'h81);
        chk("periph in A", periph_in[7:0], 8'h66);
        rd_reg(16'h0002, d);
        chk("data B", d | pin_out[15:8], 8'h00);
        rd_reg(16'h000A, d);
        chk("data F", d, 8'hFF);
        periph[4] <= '{8'hFF, 8'h0F, 8'h05, 8'h00, 8'h00};
        periph[3] <= '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h00};
        periph[6].kbd_en <= 8'h01;
        osc_en <= 1'b1;
        wr_reg(16'h0008, 8'hAA);
        wr_reg(16'h0009, 8'hF0);
        wr_reg(16'h0006, 8'h80);
        wr_reg(16'h0007, 8'h80);
        wr_reg(16'h000C, 8'hFF);
        settle();
        rd_reg(16'h0008, d);
        chk("data E", d, 8'hA5);
        chk("oe E", pin_oe_n[39:32], 8'hF0);
        chk("out E", pin_out[39:32] & 8'h0F, 8'h05);
        rd_reg(16'h0006, d);
        chk("data D", d, 8'h7F);
        chk("oe D", pin_oe_n[31:24], 8'h80);
        chk("slew D", slew_en[31:24], 8'h7F);
        rd_reg(16'h000C, d);
        chk("data G", d, 8'h7F);
        chk("oe G", pin_oe_n[55:48], 8'hE1);
        chk("slew G", slew_en[55:48], 8'h1F);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd_reg(16'h0001, d);
        chk("dir after reset", d, 8'h00);
        report_and_stop();
    end
endmodule // tb_top
